/* rtl/irqv_pkg.sv */
// irqv_pkg: register map, field layout and encodings of the interrupt level / dma vector block
package irqv_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PAIR_A_CTRL = 8'h79;
  localparam logic [7:0] IDX_PAIR_B_CTRL = 8'h7a;
  localparam logic [7:0] IDX_DMA_CH0_VEC = 8'h7c;
  localparam logic [7:0] IDX_DMA_CH1_VEC = 8'h7d;
  localparam logic [7:0] IDX_DMA_CH2_VEC = 8'h7e;
  localparam logic [7:0] IDX_DMA_CH3_VEC = 8'h7f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
  localparam logic [7:0] IDX_EXT_MODE = 8'h62;
  localparam logic [7:0] IDX_CAP_MODE = 8'h63;
  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 4;
  localparam int NUM_PIN = 4;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 9;
  localparam int VREG_W = 5;
  localparam int VREG_LSB = 4;
  localparam int FLAG_LO = 3;
  localparam int PRIO_HI_LSB = 4;
  localparam int FLAG_HI = 7;
  localparam int MODE_NMI_BOTH = 0;
  localparam int MODE_EXT_IRQ_PIN_ZERO_LEVEL = 1;
  localparam int CAPB_LSB = 2;
  // status / mask bit positions, also the pin order of the edge detectors
  localparam int ST_NMI = 0;
  localparam int ST_EXT_IRQ_PIN_ZERO = 1;
  localparam int ST_CAPA = 2;
  localparam int ST_CAPB = 3;
  localparam int ST_W = 4;
  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_OFF_LO = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_OFF_HI = 3'h7;
  localparam logic [1:0] CAP_MODE_FALL = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [VREG_W-1:0] VREG_RESET = 5'h00;
  localparam logic [3:0] VEC_LOW_ZERO = 4'h0;
endpackage : irqv_pkg

/* rtl/irqv_edge_det.sv */
// irqv_edge_det: pin synchroniser with selectable rising / falling edge detection
`timescale 1ns/1ps
module irqv_edge_det (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  input wire logic riseEn,
  input wire logic fallEn,
  output logic edgePulse,
  output logic pinLevel
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // two flops before any logic looks at the pin; third holds the old level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // one-cycle pulse on the selected edge(s)
  assign edgePulse = (riseEn & sync_ff & ~last_ff) | (fallEn & ~sync_ff & last_ff);
  assign pinLevel = sync_ff;
endmodule : irqv_edge_det

/* rtl/irqv_vec_match.sv */
// irqv_vec_match: finds the lowest channel whose start vector matches a request vector
`timescale 1ns/1ps
module irqv_vec_match
  import irqv_pkg::*;
(
  input wire logic [VREG_W-1:0] vecCh0,
  input wire logic [VREG_W-1:0] vecCh1,
  input wire logic [VREG_W-1:0] vecCh2,
  input wire logic [VREG_W-1:0] vecCh3,
  input wire logic [VEC_W-1:0] reqVector,
  output logic hit,
  output logic [1:0] hitCh
);
  logic [NUM_CH-1:0] chHit;
  logic [VREG_W-1:0] vecArr [NUM_CH];

  assign vecArr[0] = vecCh0;
  assign vecArr[1] = vecCh1;
  assign vecArr[2] = vecCh2;
  assign vecArr[3] = vecCh3;

  // a cleared register holds no source, so zero never matches
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_cmp
      assign chHit[g] = (vecArr[g] != VREG_RESET) &&
                        (vecArr[g] == reqVector[VEC_W-1:VREG_LSB]) &&
                        (reqVector[VREG_LSB-1:0] == VEC_LOW_ZERO);
    end
  endgenerate

  // lowest number wins when several channels share a vector
  assign hit = |chHit;
  assign hitCh = chHit[0] ? 2'd0 : chHit[1] ? 2'd1 : chHit[2] ? 2'd2 : 2'd3;
endmodule : irqv_vec_match

/* rtl/irqv_ctrl.sv */
// irqv_ctrl: interrupt levels, flags, pin edge selection and dma start vector routing
//
// Function
// - three-bit write-only priority per source; value is the request level used in arbitration
// - nmi pin fires on falling edge, or on both edges when both-edge bit set
// - capture pin a fires on rising edge, falling edge only for capture mode 10
// - capture pin b uses timer b capture mode the same way
// - request whose vector matches a channel start vector starts dma instead of interrupt
// - count reaching zero raises channel end interrupt and clears its start vector
// - several channels with one vector: lowest-numbered channel services the request
// - after that channel finishes unrewritten, next higher channel with same vector starts
// - start vectors write-only, bits 4..0 hold vector bits 8..4, reset to zero
// - ext_irq_pin_zero edge to level clears its flag; level to edge leaves it
// - in level mode the ext_irq_pin_zero pin level itself is the pending request
`timescale 1ns/1ps
module irqv_ctrl
  import irqv_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [DATA_W-1:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [DATA_W-1:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic nmiPin,
  input wire logic extIrqPinZero,
  input wire logic captureIrqPinA,
  input wire logic captureIrqPinB,
  input wire logic reqVecValid,
  input wire logic [VEC_W-1:0] reqVector,
  input wire logic [NUM_CH-1:0] dmaCountZero,
  output logic dmaStart,
  output logic [1:0] dmaStartCh,
  output logic cpuIrqReq,
  output logic [VEC_W-1:0] cpuIrqVector,
  output logic [PRIO_W-1:0] pendLevel,
  output logic [1:0] pendSrc,
  output logic irqOut
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic waitReq_ff;
  logic [DATA_W-1:0] readData_ff;
  logic [PRIO_W-1:0] prio_ff [NUM_CH];
  logic [NUM_CH-1:0] endFlag_ff;
  logic [VREG_W-1:0] startVec_ff [NUM_CH];
  logic [ST_W-1:0] status_ff;
  logic [ST_W-1:0] mask_ff;
  logic nmiBoth_ff;
  logic int0Level_ff;
  logic [1:0] capModeA_ff;
  logic [1:0] capModeB_ff;
  logic dmaStart_ff;
  logic [1:0] dmaCh_ff;
  logic cpuIrq_ff;
  logic [VEC_W-1:0] cpuVec_ff;
  logic [PRIO_W-1:0] pendLevel_ff;
  logic [1:0] pendSrc_ff;
  logic irq_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    isReg = (addr[ADDR_W-1:2] == idx);
  endfunction : isReg

  // request is taken in the cycle waitrequest is already low
  wire busReq = avsRead | avsWrite;
  wire wrTake = avsWrite & ~waitReq_ff & avsByteEnable[0];
  wire [7:0] wrByte = avsWriteData[7:0];
  wire wrPairA = wrTake & isReg(avsAddress, IDX_PAIR_A_CTRL);
  wire wrPairB = wrTake & isReg(avsAddress, IDX_PAIR_B_CTRL);
  wire wrStatus = wrTake & isReg(avsAddress, IDX_IRQ_STATUS);
  wire wrMask = wrTake & isReg(avsAddress, IDX_IRQ_MASK);
  wire wrMode = wrTake & isReg(avsAddress, IDX_EXT_MODE);
  wire wrCap = wrTake & isReg(avsAddress, IDX_CAP_MODE);
  wire [NUM_CH-1:0] wrVec;
  assign wrVec[0] = wrTake & isReg(avsAddress, IDX_DMA_CH0_VEC);
  assign wrVec[1] = wrTake & isReg(avsAddress, IDX_DMA_CH1_VEC);
  assign wrVec[2] = wrTake & isReg(avsAddress, IDX_DMA_CH2_VEC);
  assign wrVec[3] = wrTake & isReg(avsAddress, IDX_DMA_CH3_VEC);

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  wire [NUM_PIN-1:0] pinVec = {captureIrqPinB, captureIrqPinA, extIrqPinZero, nmiPin};
  wire [NUM_PIN-1:0] riseEn;
  wire [NUM_PIN-1:0] fallEn;
  wire [NUM_PIN-1:0] pinEdge;
  wire [NUM_PIN-1:0] pinLvl;
  assign riseEn[ST_NMI] = nmiBoth_ff;
  assign fallEn[ST_NMI] = 1'b1;
  assign riseEn[ST_EXT_IRQ_PIN_ZERO] = 1'b1;
  assign fallEn[ST_EXT_IRQ_PIN_ZERO] = 1'b0;
  assign riseEn[ST_CAPA] = (capModeA_ff != CAP_MODE_FALL);
  assign fallEn[ST_CAPA] = (capModeA_ff == CAP_MODE_FALL);
  assign riseEn[ST_CAPB] = (capModeB_ff != CAP_MODE_FALL);
  assign fallEn[ST_CAPB] = (capModeB_ff == CAP_MODE_FALL);

  genvar g;
  generate
    for (g = 0; g < NUM_PIN; g++) begin : gen_pin
      irqv_edge_det uEdge (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinIn(pinVec[g]),
        .riseEn(riseEn[g]),
        .fallEn(fallEn[g]),
        .edgePulse(pinEdge[g]),
        .pinLevel(pinLvl[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status bits: set wins over the write-one clear
  // ----------------------------------------------------------------
  // edge into level clears ext_irq_pin_zero; in level mode the bit follows the pin, so on
  // the way back to edge whatever the pin last showed stays as the flag
  wire toLevel = wrMode & wrByte[MODE_EXT_IRQ_PIN_ZERO_LEVEL] & ~int0Level_ff;
  wire [ST_W-1:0] stClr = wrStatus ? wrByte[ST_W-1:0] : '0;
  wire [ST_W-1:0] stSet = pinEdge & ~(int0Level_ff ? (ST_W'(1) << ST_EXT_IRQ_PIN_ZERO) : '0);
  wire [ST_W-1:0] stSticky = (status_ff & ~stClr) | stSet;
  wire int0Next = int0Level_ff ? pinLvl[ST_EXT_IRQ_PIN_ZERO] : (toLevel ? 1'b0 : stSticky[ST_EXT_IRQ_PIN_ZERO]);
  wire [ST_W-1:0] nxt_status = {stSticky[ST_CAPB], stSticky[ST_CAPA], int0Next,
                                stSticky[ST_NMI]};
  // level mode bypasses the flag: the pin itself is the request
  wire [ST_W-1:0] stView = int0Level_ff ?
                           ((status_ff & ~(ST_W'(1) << ST_EXT_IRQ_PIN_ZERO)) |
                            (ST_W'(pinLvl[ST_EXT_IRQ_PIN_ZERO]) << ST_EXT_IRQ_PIN_ZERO)) : status_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ----------------------------------------------------------------
  // mode registers and dma end flags / priorities
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= '0;
      nmiBoth_ff <= 1'b0;
      int0Level_ff <= 1'b0;
      capModeA_ff <= '0;
      capModeB_ff <= '0;
    end else begin
      if (wrMask) mask_ff <= wrByte[ST_W-1:0];
      if (wrMode) begin
        nmiBoth_ff <= wrByte[MODE_NMI_BOTH];
        int0Level_ff <= wrByte[MODE_EXT_IRQ_PIN_ZERO_LEVEL];
      end
      if (wrCap) begin
        capModeA_ff <= wrByte[1:0];
        capModeB_ff <= wrByte[CAPB_LSB+1:CAPB_LSB];
      end
    end
  end

  // per source: pair a holds channels 0/1, pair b channels 2/3
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_src
      wire wrPair = (g < 2) ? wrPairA : wrPairB;
      wire hiHalf = (g % 2) == 1;
      wire [PRIO_W-1:0] wPrio = hiHalf ? wrByte[PRIO_HI_LSB+PRIO_W-1:PRIO_HI_LSB] :
                                         wrByte[PRIO_W-1:0];
      wire wFlag = hiHalf ? wrByte[FLAG_HI] : wrByte[FLAG_LO];
      // writing 0 clears, 1 leaves; a new end event wins over the clear
      wire nxt_flag = dmaCountZero[g] | (endFlag_ff[g] & ~(wrPair & ~wFlag));
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          prio_ff[g] <= '0;
          endFlag_ff[g] <= 1'b0;
          startVec_ff[g] <= VREG_RESET;
        end else begin
          if (wrPair) prio_ff[g] <= wPrio;
          endFlag_ff[g] <= nxt_flag;
          // a rewrite in the completion cycle re-arms the channel
          if (wrVec[g]) startVec_ff[g] <= wrByte[VREG_W-1:0];
          else if (dmaCountZero[g]) startVec_ff[g] <= VREG_RESET;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // dma routing of incoming requests
  // ----------------------------------------------------------------
  wire vecHit;
  wire [1:0] vecHitCh;
  irqv_vec_match uMatch (
    .vecCh0(startVec_ff[0]),
    .vecCh1(startVec_ff[1]),
    .vecCh2(startVec_ff[2]),
    .vecCh3(startVec_ff[3]),
    .reqVector(reqVector),
    .hit(vecHit),
    .hitCh(vecHitCh)
  );

  // cleared vectors drop out of the match, which is what chains the channels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dmaStart_ff <= 1'b0;
      dmaCh_ff <= '0;
      cpuIrq_ff <= 1'b0;
      cpuVec_ff <= '0;
    end else begin
      dmaStart_ff <= reqVecValid & vecHit;
      cpuIrq_ff <= reqVecValid & ~vecHit;
      if (reqVecValid) begin
        dmaCh_ff <= vecHitCh;
        cpuVec_ff <= reqVector;
      end
    end
  end

  // ----------------------------------------------------------------
  // level arbitration over pending end flags
  // ----------------------------------------------------------------
  // levels 000 and 111 forbid the request; higher level wins, ties go low
  function automatic logic [PRIO_W+1:0] pickHighest(
    input logic [NUM_CH-1:0] pend,
    input logic [PRIO_W-1:0] l0, input logic [PRIO_W-1:0] l1,
    input logic [PRIO_W-1:0] l2, input logic [PRIO_W-1:0] l3);
    logic [PRIO_W-1:0] lv [NUM_CH];
    logic [PRIO_W-1:0] best;
    logic [1:0] src;
    lv[0] = l0;
    lv[1] = l1;
    lv[2] = l2;
    lv[3] = l3;
    best = PRIO_OFF_LO;
    src = 2'd0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pend[i] && lv[i] != PRIO_OFF_HI && lv[i] > best) begin
        best = lv[i];
        src = 2'(i);
      end
    end
    pickHighest = {best, src};
  endfunction : pickHighest

  wire [PRIO_W+1:0] arb = pickHighest(endFlag_ff, prio_ff[0], prio_ff[1],
                                      prio_ff[2], prio_ff[3]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendLevel_ff <= '0;
      pendSrc_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      pendLevel_ff <= arb[PRIO_W+1:2];
      pendSrc_ff <= arb[1:0];
      irq_ff <= |(stView & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, read data registered
  // ----------------------------------------------------------------
  wire [7:0] rdPairA = {endFlag_ff[1], 3'b000, endFlag_ff[0], 3'b000};
  wire [7:0] rdPairB = {endFlag_ff[3], 3'b000, endFlag_ff[2], 3'b000};
  // priorities and start vectors are write-only and read as zero
  wire [7:0] rdMux =
    isReg(avsAddress, IDX_PAIR_A_CTRL) ? rdPairA :
    isReg(avsAddress, IDX_PAIR_B_CTRL) ? rdPairB :
    isReg(avsAddress, IDX_IRQ_STATUS) ? {4'h0, stView} :
    isReg(avsAddress, IDX_IRQ_MASK) ? {4'h0, mask_ff} :
    isReg(avsAddress, IDX_EXT_MODE) ? {6'h00, int0Level_ff, nmiBoth_ff} :
    isReg(avsAddress, IDX_CAP_MODE) ? {4'h0, capModeB_ff, capModeA_ff} : REG_RESET;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReq_ff <= 1'b1;
      readData_ff <= '0;
    end else begin
      waitReq_ff <= ~(busReq & waitReq_ff);
      if (avsRead & waitReq_ff) readData_ff <= {24'h00_0000, rdMux};
    end
  end

  assign avsWaitRequest = waitReq_ff;
  assign avsReadData = readData_ff;
  assign dmaStart = dmaStart_ff;
  assign dmaStartCh = dmaCh_ff;
  assign cpuIrqReq = cpuIrq_ff;
  assign cpuIrqVector = cpuVec_ff;
  assign pendLevel = pendLevel_ff;
  assign pendSrc = pendSrc_ff;
  assign irqOut = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_dma_route: assert property (reqVecValid && vecHit |=> dmaStart && !cpuIrqReq)
    else $error("matching vector did not start dma");
  a_cpu_route: assert property (reqVecValid && !vecHit |=> cpuIrqReq && !dmaStart)
    else $error("unmatched vector not passed to cpu");
  a_low_ch_wins: assert property (reqVecValid && startVec_ff[0] != VREG_RESET &&
      startVec_ff[0] == reqVector[VEC_W-1:VREG_LSB] && reqVector[VREG_LSB-1:0] == VEC_LOW_ZERO
      |=> dmaStartCh == 2'd0)
    else $error("channel zero did not win a shared vector");
  a_vec_clear: assert property (dmaCountZero[0] && !wrVec[0] |=> startVec_ff[0] == VREG_RESET
      && endFlag_ff[0])
    else $error("count zero did not clear vector or raise end flag");
  a_chain_next: assert property (reqVecValid && startVec_ff[0] == VREG_RESET &&
      startVec_ff[1] != VREG_RESET && startVec_ff[1] == reqVector[VEC_W-1:VREG_LSB] &&
      reqVector[VREG_LSB-1:0] == VEC_LOW_ZERO |=> dmaStart && dmaStartCh == 2'd1)
    else $error("chained channel one not started");
  a_vec_write: assert property (wrVec[2] |=> startVec_ff[2] == $past(wrByte[VREG_W-1:0]))
    else $error("start vector write lost");
  a_flag_clear: assert property (wrPairA && !wrByte[FLAG_LO] && !dmaCountZero[0]
      |=> !endFlag_ff[0])
    else $error("writing zero did not clear request flag");
  a_flag_keep: assert property (endFlag_ff[1] && !(wrPairA && !wrByte[FLAG_HI])
      |=> endFlag_ff[1])
    else $error("request flag lost without a zero write");
  a_nmi_fall: assert property (!nmiBoth_ff && pinLvl[ST_NMI] ##1 !pinLvl[ST_NMI]
      && !nmiBoth_ff |-> pinEdge[ST_NMI])
    else $error("nmi falling edge missed");
  a_nmi_rise: assert property ($rose(pinLvl[ST_NMI]) |-> pinEdge[ST_NMI] == nmiBoth_ff)
    else $error("nmi rising edge handled against mode");
  a_capa_edge: assert property ($fell(pinLvl[ST_CAPA]) |->
      pinEdge[ST_CAPA] == (capModeA_ff == CAP_MODE_FALL))
    else $error("capture a falling edge handled against mode");
  a_capb_edge: assert property ($rose(pinLvl[ST_CAPB]) |->
      pinEdge[ST_CAPB] == (capModeB_ff != CAP_MODE_FALL))
    else $error("capture b rising edge handled against mode");
  a_ext_irq_pin_zero_level: assert property ($past(int0Level_ff) |->
      status_ff[ST_EXT_IRQ_PIN_ZERO] == $past(pinLvl[ST_EXT_IRQ_PIN_ZERO]))
    else $error("level mode ext_irq_pin_zero not following pin");
  a_ext_irq_pin_zero_to_lvl: assert property (toLevel |=> !status_ff[ST_EXT_IRQ_PIN_ZERO])
    else $error("edge to level did not clear ext_irq_pin_zero flag");
  a_arb_level: assert property (endFlag_ff == 4'b0001 && prio_ff[0] != PRIO_OFF_HI
      |=> pendLevel == $past(prio_ff[0]))
    else $error("pending level does not follow priority field");

  c_dma_start: cover property (reqVecValid && vecHit ##1 dmaStart);
  c_chain: cover property (dmaCountZero[0] ##[1:20] (dmaStart && dmaStartCh == 2'd1));
  c_ext_irq_pin_zero_level: cover property (toLevel ##[1:10] stView[ST_EXT_IRQ_PIN_ZERO]);
  c_irq_out: cover property ($rose(irqOut));
endmodule : irqv_ctrl

/* testbench/irqv_dma_model.sv */
// irqv_dma_model: behavioural dma engine that ends a channel after a fixed number of starts
`timescale 1ns/1ps
module irqv_dma_model
  import irqv_pkg::*;
#(
  parameter int XFER_COUNT = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dmaStart,
  input wire logic [1:0] dmaStartCh,
  output logic [NUM_CH-1:0] dmaCountZero
);
  int xferCnt_ff[NUM_CH];
  logic endNow;
  assign endNow = dmaStart && (xferCnt_ff[dmaStartCh] == XFER_COUNT - 1);
  // count starts per channel; a small count keeps the chaining test short
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xferCnt_ff <= '{default: 0};
      dmaCountZero <= '0;
    end else begin
      dmaCountZero <= endNow ? (NUM_CH'(1) << dmaStartCh) : '0; // one-cycle end pulse
      if (dmaStart) xferCnt_ff[dmaStartCh] <= endNow ? 0 : xferCnt_ff[dmaStartCh] + 1;
    end
  end
endmodule : irqv_dma_model

/* testbench/irq_level_and_dma_vector_assign_bench.sv */
// irq_level_and_dma_vector_assign_bench: self-checking bench of the level / vector block
`timescale 1ns/1ps
module irq_level_and_dma_vector_assign_bench;
  import irqv_pkg::*;
  logic clk, sys_rst, avsRead, avsWrite, avsWaitRequest, reqVecValid, dmaStart, cpuIrqReq, irqOut;
  logic nmiPin, extIrqPinZero, captureIrqPinA, captureIrqPinB;
  logic [ADDR_W-1:0] avsAddress;
  logic [DATA_W-1:0] avsWriteData, avsReadData;
  logic [3:0] avsByteEnable;
  logic [VEC_W-1:0] reqVector, cpuIrqVector;
  logic [NUM_CH-1:0] dmaCountZero;
  logic [1:0] dmaStartCh, pendSrc;
  logic [PRIO_W-1:0] pendLevel;
  int failCount, numChecks, cycles;
  // ----------------------------------------------------------------
  // design, far-side dma model, clock
  // ----------------------------------------------------------------
  irqv_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .nmiPin(nmiPin),
    .extIrqPinZero(extIrqPinZero), .captureIrqPinA(captureIrqPinA),
    .captureIrqPinB(captureIrqPinB), .reqVecValid(reqVecValid), .reqVector(reqVector),
    .dmaCountZero(dmaCountZero), .dmaStart(dmaStart), .dmaStartCh(dmaStartCh),
    .cpuIrqReq(cpuIrqReq), .cpuIrqVector(cpuIrqVector), .pendLevel(pendLevel),
    .pendSrc(pendSrc), .irqOut(irqOut));
  irqv_dma_model #(.XFER_COUNT(2)) i_dma (.clk(clk), .sys_rst(sys_rst), .dmaStart(dmaStart),
    .dmaStartCh(dmaStartCh), .dmaCountZero(dmaCountZero));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // one avalon cycle; request held until waitrequest is sampled low
  task automatic busXfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                         output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= {idx, 2'b00};
    avsWriteData <= DATA_W'(d);
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 100);
    rd = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    check(n < 100, 1'b1, "bus answer");
  endtask : busXfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    busXfer(1'b1, idx, d, x);
  endtask : wr
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] x;
    busXfer(1'b0, idx, 8'h00, x);
    check(x, exp, what);
  endtask : rdChk
  // result is registered on the edge that takes the request
  task automatic sendReq(input logic [VEC_W-1:0] v, input logic isDma, input logic [1:0] ch);
    @(posedge clk);
    reqVecValid <= 1'b1;
    reqVector <= v;
    @(posedge clk);
    reqVecValid <= 1'b0;
    #1;
    check({dmaStart, cpuIrqReq, isDma ? dmaStartCh : 2'b00}, {isDma, !isDma, ch}, "route");
    if (!isDma) check(cpuIrqVector, v, "cpu vector");
  endtask : sendReq
  // pins in status bit order; 6 cycles covers sync, edge compare and status set
  task automatic setPins(input logic [3:0] p);
    @(posedge clk);
    {captureIrqPinB, captureIrqPinA, extIrqPinZero, nmiPin} <= p;
    repeat (6) @(posedge clk);
  endtask : setPins
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testRouting();
    rdChk(IDX_PAIR_A_CTRL, 8'h00, "pair a reset");
    rdChk(IDX_PAIR_B_CTRL, 8'h00, "pair b reset");
    wr(8'h10, 8'hff);
    rdChk(8'h10, 8'h00, "unmapped");
    wr(IDX_DMA_CH0_VEC, 8'h12);
    wr(IDX_DMA_CH1_VEC, 8'h12);
    rdChk(IDX_DMA_CH0_VEC, 8'h00, "vector write-only");
    wr(IDX_DMA_CH2_VEC, 8'h15);
    avsByteEnable <= 4'h0;
    wr(IDX_IRQ_MASK, 8'h0f);
    avsByteEnable <= 4'h1;
    rdChk(IDX_IRQ_MASK, 8'h00, "byte enable off ignored");
    sendReq(9'h120, 1'b1, 2'd0);
    sendReq(9'h130, 1'b0, 2'd0);
    $display("routing test done");
  endtask : testRouting
  task automatic testChain();
    sendReq(9'h120, 1'b1, 2'd0);
    // end pulse lands one edge after the start, flag two edges after it
    repeat (2) @(posedge clk);
    rdChk(IDX_PAIR_A_CTRL, 8'h08, "ch0 end flag");
    sendReq(9'h120, 1'b1, 2'd1);
    sendReq(9'h120, 1'b1, 2'd1);
    repeat (2) @(posedge clk);
    rdChk(IDX_PAIR_A_CTRL, 8'h88, "ch1 end flag");
    sendReq(9'h120, 1'b0, 2'd0);
    wr(IDX_DMA_CH0_VEC, 8'h12);
    sendReq(9'h120, 1'b1, 2'd0);
    $display("chain test done");
  endtask : testChain
  task automatic testFlags();
    wr(IDX_PAIR_A_CTRL, 8'hd5);
    rdChk(IDX_PAIR_A_CTRL, 8'h80, "flag clear by zero");
    check(pendLevel, 3'd5, "level");
    check(pendSrc, 2'd1, "level source");
    wr(IDX_PAIR_A_CTRL, 8'h00);
    rdChk(IDX_PAIR_A_CTRL, 8'h00, "flags cleared");
    check(pendLevel, 3'd0, "no level");
    $display("flag test done");
  endtask : testFlags
  task automatic testNmi();
    wr(IDX_IRQ_MASK, 8'h0f);
    wr(IDX_IRQ_STATUS, 8'h0f);
    setPins(4'b0000);
    rdChk(IDX_IRQ_STATUS, 8'h01, "nmi fall");
    check(irqOut, 1'b1, "irq raised");
    wr(IDX_IRQ_STATUS, 8'h01);
    setPins(4'b0001);
    rdChk(IDX_IRQ_STATUS, 8'h00, "nmi rise ignored");
    wr(IDX_EXT_MODE, 8'h01);
    setPins(4'b0000);
    rdChk(IDX_IRQ_STATUS, 8'h01, "nmi fall both");
    wr(IDX_IRQ_STATUS, 8'h01);
    setPins(4'b0001);
    rdChk(IDX_IRQ_STATUS, 8'h01, "nmi rise both");
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check(irqOut, 1'b0, "irq masked");
    wr(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_MASK, 8'h0f);
    wr(IDX_EXT_MODE, 8'h00);
    $display("nmi test done");
  endtask : testNmi
  task automatic testCapture();
    logic [7:0] rise;
    for (int m = 0; m < 4; m++) begin
      rise = (m == 2) ? 8'h00 : 8'h0c;
      wr(IDX_CAP_MODE, {4'h0, 2'(m), 2'(m)});
      setPins(4'b1101);
      rdChk(IDX_IRQ_STATUS, rise, "capture rise");
      wr(IDX_IRQ_STATUS, 8'h0f);
      setPins(4'b0001);
      rdChk(IDX_IRQ_STATUS, rise ^ 8'h0c, "capture fall");
      wr(IDX_IRQ_STATUS, 8'h0f);
    end
    $display("capture test done");
  endtask : testCapture
  task automatic testInt0();
    setPins(4'b0011);
    setPins(4'b0001);
    rdChk(IDX_IRQ_STATUS, 8'h02, "ext_irq_pin_zero edge flag");
    wr(IDX_EXT_MODE, 8'h02);
    rdChk(IDX_IRQ_STATUS, 8'h00, "edge to level clears");
    setPins(4'b0011);
    rdChk(IDX_IRQ_STATUS, 8'h02, "level follows pin");
    wr(IDX_IRQ_STATUS, 8'h02);
    rdChk(IDX_IRQ_STATUS, 8'h02, "level not cleared");
    wr(IDX_EXT_MODE, 8'h00);
    rdChk(IDX_IRQ_STATUS, 8'h02, "level to edge keeps");
    wr(IDX_IRQ_STATUS, 8'h02);
    $display("ext_irq_pin_zero test done");
  endtask : testInt0
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tallyAndFinish
  // main sequence; nmi idles high so its release edge is a harmless rise
  initial begin
    {sys_rst, nmiPin, avsByteEnable} = {1'b1, 1'b1, 4'h1};
    {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    {extIrqPinZero, captureIrqPinA, captureIrqPinB, reqVecValid, reqVector} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    testRouting();
    testChain();
    testFlags();
    testNmi();
    testCapture();
    testInt0();
    tallyAndFinish();
  end
endmodule : irq_level_and_dma_vector_assign_bench
